//--- logic/amr_mute_ramp_ctrl.sv
// mute and gain ramp control for eight stereo rate converters
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`include "amr_regs.svh"

module amr_mute_ramp_ctrl
  import amr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [7:0] rate_target_set,
  input wire logic [7:0] rate_input_steady,
  input wire logic [7:0] ratio_ready,
  input wire logic [7:0] sample_stb,
  input wire amr_sample_t [7:0] in_left,
  input wire amr_sample_t [7:0] in_right,
  output amr_sample_t [7:0] out_left,
  output amr_sample_t [7:0] out_right,
  output logic [7:0] out_valid,
  output amr_gain_t [7:0] gain_level,
  output logic [7:0] conv_muted
);

  logic [15:0] converter_mute_control;
  logic [7:0] converter_lock_flags;
  logic [7:0] converter_manual_mute;
  logic ramp_disable_low_group;
  logic ramp_disable_high_group;
  logic auto_mute_on_unlock;
  logic [7:0] bypass;
  logic [7:0] mute_req;
  logic [7:0] conv_ramping;
  logic [15:0] rd_value;

  // -----------------------------------------------------------------
  // mute control register
  // -----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      converter_mute_control <= `AMR_MUTE_RESET;
    end else if (clk_en && reg_wr && reg_addr == `AMR_MUTE_OFS) begin
      converter_mute_control <= reg_wdata & `AMR_MUTE_WR_MASK;
    end
  end

  assign converter_manual_mute =
    converter_mute_control[`AMR_MANUAL_MSB:`AMR_MANUAL_LSB];
  assign ramp_disable_low_group =
    converter_mute_control[`AMR_RAMP_DIS_LO_BIT];
  assign ramp_disable_high_group =
    converter_mute_control[`AMR_RAMP_DIS_HI_BIT];
  assign auto_mute_on_unlock = converter_mute_control[`AMR_AUTO_MUTE_BIT];

  // -----------------------------------------------------------------
  // lock and mute request per converter
  // -----------------------------------------------------------------
  // all three lock conditions
  assign converter_lock_flags =
    rate_target_set & rate_input_steady & ratio_ready;

  // low group is 3..0, high group 7..4
  assign bypass = {{4{ramp_disable_high_group}},
                   {4{ramp_disable_low_group}}};

  // auto mute on unlock, manual wins, auto off
  assign mute_req = ~bypass & (converter_manual_mute |
                    ({8{auto_mute_on_unlock}} & ~converter_lock_flags));

  // -----------------------------------------------------------------
  // gain ramps
  // -----------------------------------------------------------------
  // linear ramps, auto mute ramps, reversal
  for (genvar i = 0; i < 8; i++) begin : g_conv
    amr_gain_ramp u_ramp (
      .clk(clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .sample_stb(sample_stb[i]),
      .mute_req(mute_req[i]),
      .bypass(bypass[i]),
      .in_left(in_left[i]),
      .in_right(in_right[i]),
      .out_left(out_left[i]),
      .out_right(out_right[i]),
      .out_valid(out_valid[i]),
      .gain(gain_level[i]),
      .muted(conv_muted[i]),
      .ramping(conv_ramping[i])
    );
  end

  // -----------------------------------------------------------------
  // register readback
  // -----------------------------------------------------------------
  always_comb begin
    if (reg_addr == `AMR_MUTE_OFS) begin
      rd_value = converter_mute_control;
    end else if (reg_addr == `AMR_LOCK_OFS) begin
      rd_value = {8'h00, converter_lock_flags};
    end else if (reg_addr == `AMR_STAT_OFS) begin
      rd_value = {conv_ramping, conv_muted};
    end else begin
      rd_value = 16'h0000;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rd_value : 16'h0000;
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  amr_gain_t g0_up;
  logic [12:0] up_cnt;
  logic up_clean;

  assign g0_up = gain_level[0] + 12'h001;

  // strobes counted on a clean ramp up of converter 0
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      up_cnt <= 13'h0000;
      up_clean <= 1'b0;
    end else if (clk_en) begin
      if (gain_level[0] == `AMR_GAIN_ZERO) begin
        up_cnt <= 13'h0000;
        up_clean <= 1'b1;
      end else if (bypass[0] || mute_req[0]) begin
        up_clean <= 1'b0;
      end
      if (conv_ramping[0] && !mute_req[0] && sample_stb[0] &&
          gain_level[0] != `AMR_GAIN_FULL) begin
        up_cnt <= up_cnt + 13'h0001;
      end
    end
  end

  sequence lock_lost_s;
    clk_en && $fell(converter_lock_flags[0]) && auto_mute_on_unlock &&
      !bypass[0];
  endsequence

  sequence relock_s;
    clk_en && conv_muted[0] && converter_lock_flags[0] &&
      !converter_manual_mute[0] && !bypass[0];
  endsequence

  sequence quiet_step_s;
    clk_en && !bypass[0] && !sample_stb[0];
  endsequence

  // manual mute bit drives the request
  manual_mute_a: assert property (
    clk_en && converter_manual_mute[1] && !bypass[1] |->
      mute_req[1] ##1 (!clk_en || conv_muted[1] || conv_ramping[1]))
    else $error("manual mute bit did not request a mute");

  ramp_bypass_a: assert property (
    clk_en && ramp_disable_high_group |=>
      gain_level[6] == `AMR_GAIN_FULL && !conv_muted[6])
    else $error("disabled group not at unity gain");

  group_ignore_a: assert property (
    clk_en && ramp_disable_low_group && converter_manual_mute[2] |=>
      gain_level[2] == `AMR_GAIN_FULL)
    else $error("manual mute acted on a disabled group");

  // gain moves one step down per strobe while ramping down
  linear_step_a: assert property (
    clk_en && !bypass[0] && sample_stb[0] && conv_ramping[0] &&
      mute_req[0] && $past(mute_req[0]) &&
      gain_level[0] != `AMR_GAIN_ZERO |=>
      g0_up == $past(gain_level[0]))
    else $error("ramp down step not one unit");

  no_jump_a: assert property (
    quiet_step_s |=> $stable(gain_level[0]))
    else $error("gain changed without a sample strobe");

  // a clean full ramp takes 2048 strobes
  ramp_length_a: assert property (
    clk_en && up_clean && !bypass[0] && conv_ramping[0] &&
      gain_level[0] == `AMR_GAIN_FULL |->
      up_cnt == 13'(`AMR_RAMP_SAMPLES))
    else $error("ramp length not 2048 samples");

  auto_mute_a: assert property (
    clk_en && auto_mute_on_unlock && !converter_lock_flags[3] &&
      !bypass[3] |-> mute_req[3])
    else $error("unlock did not request a mute");

  // lock loss ramps rather than cuts
  no_click_a: assert property (
    lock_lost_s |=> g0_up >= $past(gain_level[0]) &&
      (conv_ramping[0] || conv_muted[0] || !clk_en))
    else $error("lock loss cut the gain");

  // relock with manual clear starts ramp up
  auto_unmute_a: assert property (
    relock_s |=> conv_ramping[0] && !conv_muted[0])
    else $error("relock did not start a ramp up");

  manual_wins_a: assert property (
    clk_en && converter_manual_mute[4] && converter_lock_flags[4] &&
      !bypass[4] |-> mute_req[4])
    else $error("lock overrode the manual mute");

  // without auto mute only manual bits count
  auto_off_a: assert property (
    !auto_mute_on_unlock |->
      mute_req == (converter_manual_mute & ~bypass))
    else $error("mute requested without a manual bit");

  reset_value_a: assert property (
    $past(!rst_n) |-> converter_mute_control == `AMR_MUTE_RESET)
    else $error("mute control not zero after reset");

  // lock flags read back as computed
  lock_read_a: assert property (
    clk_en && reg_rd && reg_addr == `AMR_LOCK_OFS |=>
      !clk_en || reg_rdata == {8'h00, $past(converter_lock_flags)})
    else $error("lock flags read back wrong");

  // -----------------------------------------------------------------
  // further checks on bus, gain and outputs
  // -----------------------------------------------------------------
  // read data only after a read
  rdata_idle_a: assert property (
    clk_en && !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero without a read");

  mute_read_a: assert property (
    clk_en && reg_rd && reg_addr == `AMR_MUTE_OFS |=>
      reg_rdata == $past(converter_mute_control))
    else $error("mute control read back wrong");

  // write lands with reserved bits masked
  write_lands_a: assert property (
    clk_en && reg_wr && reg_addr == `AMR_MUTE_OFS |=>
      converter_mute_control == ($past(reg_wdata) & `AMR_MUTE_WR_MASK))
    else $error("mute control write did not land");

  reserved_zero_a: assert property (
    converter_mute_control[15:11] == 5'h00)
    else $error("reserved mute control bits set");

  low_bypass_a: assert property (
    clk_en && ramp_disable_low_group |=>
      gain_level[3:0] == {4{`AMR_GAIN_FULL}})
    else $error("low group not at unity gain");

  bypass_unmuted_a: assert property (
    clk_en && bypass[7] |=> !conv_muted[7])
    else $error("disabled converter shows muted");

  // gain moves at most one unit per cycle while the converter is not bypassed
  step_size_a: assert property (
    clk_en && !bypass[4] |=>
      gain_level[4] == $past(gain_level[4]) ||
      gain_level[4] == $past(gain_level[4]) + 12'h001 ||
      gain_level[4] + 12'h001 == $past(gain_level[4]))
    else $error("gain step larger than one unit");

  muted_gain_a: assert property (
    conv_muted[5] |-> gain_level[5] == `AMR_GAIN_ZERO)
    else $error("muted converter has nonzero gain");

  unity_gain_a: assert property (
    !conv_ramping[5] && !conv_muted[5] |->
      gain_level[5] == `AMR_GAIN_FULL)
    else $error("settled converter not at unity");

  valid_follows_a: assert property (
    clk_en && sample_stb[6] |=> out_valid[6])
    else $error("output valid missing after a sample");

  valid_only_a: assert property (
    clk_en && !sample_stb[6] |=> !out_valid[6])
    else $error("output valid without a sample");

  out_hold_a: assert property (
    clk_en && !sample_stb[6] |=> $stable(out_left[6]))
    else $error("output changed without a sample");

  unlock_ramp_a: assert property (
    clk_en && auto_mute_on_unlock && !converter_lock_flags[3] &&
      !bypass[3] |=> conv_ramping[3] || conv_muted[3])
    else $error("unlock did not ramp down");

  // no manual bit, no auto: no mute
  manual_off_a: assert property (
    !auto_mute_on_unlock && !converter_manual_mute[5] |-> !mute_req[5])
    else $error("mute requested with auto mute off");

endmodule : amr_mute_ramp_ctrl

//--- logic/amr_regs.svh
// register map, field positions and counts of the mute ramp block
`ifndef AMR_REGS_SVH
`define AMR_REGS_SVH

// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define AMR_LOCK_OFS 16'hF580
`define AMR_MUTE_OFS 16'hF581
`define AMR_STAT_OFS 16'hF582

// -----------------------------------------------------------------
// mute control fields
// -----------------------------------------------------------------
`define AMR_MANUAL_MSB 7
`define AMR_MANUAL_LSB 0
`define AMR_RAMP_DIS_LO_BIT 8
`define AMR_RAMP_DIS_HI_BIT 9
`define AMR_AUTO_MUTE_BIT 10
`define AMR_MUTE_WR_MASK 16'h07FF
`define AMR_MUTE_RESET 16'h0000

// -----------------------------------------------------------------
// ramp counts, in input samples
// -----------------------------------------------------------------
`define AMR_RAMP_SAMPLES 12'h800
`define AMR_GAIN_FULL 12'h800
`define AMR_GAIN_ZERO 12'h000

`endif

//--- logic/amr_pkg.sv
// types and gain arithmetic shared by the mute ramp block
package amr_pkg;

  typedef logic [11:0] amr_gain_t;
  typedef logic signed [23:0] amr_sample_t;

  typedef enum logic [1:0] {
    AMR_HOLD_MUTED = 2'b00,
    AMR_RAMP_UP = 2'b01,
    AMR_UNITY = 2'b10,
    AMR_RAMP_DOWN = 2'b11
  } amr_state_t;

  // sample times gain, gain full scale is 2^11
  function automatic amr_sample_t amr_scale(input amr_sample_t s,
                                            input amr_gain_t g);
    logic signed [36:0] p;
    p = s * $signed({1'b0, g});
    return p[34:11];
  endfunction : amr_scale

endpackage : amr_pkg

//--- logic/amr_gain_ramp.sv
// one stereo converter: linear gain ramp and output scaling
`timescale 1ns/1ps
`include "amr_regs.svh"

module amr_gain_ramp
  import amr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic sample_stb,
  input wire logic mute_req,
  input wire logic bypass,
  input wire amr_sample_t in_left,
  input wire amr_sample_t in_right,
  output amr_sample_t out_left,
  output amr_sample_t out_right,
  output logic out_valid,
  output amr_gain_t gain,
  output logic muted,
  output logic ramping
);

  amr_state_t state_reg;
  amr_state_t state_next;
  amr_gain_t gain_reg;
  amr_gain_t gain_next;

  // -----------------------------------------------------------------
  // ramp state and gain
  // -----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    gain_next = gain_reg;
    if (bypass) begin
      state_next = AMR_UNITY;
      gain_next = `AMR_GAIN_FULL;
    end else begin
      case (state_reg)
        AMR_UNITY: begin
          if (mute_req) state_next = AMR_RAMP_DOWN;
        end
        AMR_RAMP_DOWN: begin
          // reverse from the present gain, no jump
          if (!mute_req) state_next = AMR_RAMP_UP;
          else if (gain_reg == `AMR_GAIN_ZERO) state_next = AMR_HOLD_MUTED;
          else if (sample_stb) gain_next = gain_reg - 12'h001;
        end
        AMR_RAMP_UP: begin
          if (mute_req) state_next = AMR_RAMP_DOWN;
          else if (gain_reg == `AMR_GAIN_FULL) state_next = AMR_UNITY;
          else if (sample_stb) gain_next = gain_reg + 12'h001;
        end
        default: begin
          if (!mute_req) state_next = AMR_RAMP_UP;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= AMR_UNITY;
      gain_reg <= `AMR_GAIN_FULL;
    end else if (clk_en) begin
      state_reg <= state_next;
      gain_reg <= gain_next;
    end
  end

  // -----------------------------------------------------------------
  // scaled output samples
  // -----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_left <= 24'h000000;
      out_right <= 24'h000000;
      out_valid <= 1'b0;
    end else if (clk_en) begin
      out_valid <= sample_stb;
      if (sample_stb) begin
        out_left <= amr_scale(in_left, gain_reg);
        out_right <= amr_scale(in_right, gain_reg);
      end
    end
  end

  assign gain = gain_reg;
  assign muted = (state_reg == AMR_HOLD_MUTED);
  assign ramping = state_reg[0];

endmodule : amr_gain_ramp

//--- dv/amr_src_model.sv
// converter side model: strobes, samples and lock conditions
`timescale 1ns/1ps

module amr_src_model
  import amr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic [7:0] unlock,
  input wire logic [1:0] cond_sel,
  output logic [7:0] rate_target_set,
  output logic [7:0] rate_input_steady,
  output logic [7:0] ratio_ready,
  output logic [7:0] sample_stb,
  output amr_sample_t [7:0] in_left,
  output amr_sample_t [7:0] in_right
);
  logic [1:0] div_reg;
  logic [23:0] cnt_reg;

  always_ff @(posedge clk) begin
    rate_target_set <= cond_sel == 2'h0 ? ~unlock : 8'hFF;
    rate_input_steady <= cond_sel == 2'h1 ? ~unlock : 8'hFF;
    ratio_ready <= cond_sel == 2'h2 ? ~unlock : 8'hFF;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_reg <= 2'h0;
      sample_stb <= 8'h00;
    end else begin
      div_reg <= div_reg == 2'h2 ? 2'h0 : div_reg + 2'h1;
      sample_stb <= (!slow || div_reg == 2'h0) ? 8'hFF : 8'h00;
    end
  end

  // samples move every cycle, valid only under the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= 24'h000000;
    end else begin
      cnt_reg <= cnt_reg + 24'h01234D;
    end
    for (int i = 0; i < 8; i++) begin
      in_left[i] <= cnt_reg + 24'(i);
      in_right[i] <= cnt_reg ^ 24'hA5A5A5;
    end
  end
endmodule : amr_src_model

//--- dv/converter_mute_control_ramp_control_tb_top.sv
// bench of the converter mute ramp control
`timescale 1ns/1ps
`include "amr_regs.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  num_errors++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); \
  end end

module converter_mute_control_ramp_control_tb_top import amr_pkg::*;;
  localparam logic [15:0] MR = `AMR_MUTE_OFS;
  logic clk, rst_n, wr_s, rd_s, slow, ce;
  logic [15:0] addr, wdata, rdata, rv;
  logic [7:0] rts, ris, rr, stb, ov, cm, unlock;
  logic [1:0] cond_sel;
  amr_sample_t [7:0] in_l, in_r, out_l, out_r;
  amr_gain_t [7:0] gl;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;

  amr_src_model src (.clk(clk), .rst_n(rst_n), .slow(slow),
    .unlock(unlock), .cond_sel(cond_sel), .rate_target_set(rts),
    .rate_input_steady(ris), .ratio_ready(rr), .sample_stb(stb),
    .in_left(in_l), .in_right(in_r));

  amr_mute_ramp_ctrl uut (.clk(clk), .rst_n(rst_n), .clk_en(ce),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr_s), .reg_rd(rd_s),
    .reg_rdata(rdata), .rate_target_set(rts), .rate_input_steady(ris),
    .ratio_ready(rr), .sample_stb(stb), .in_left(in_l), .in_right(in_r),
    .out_left(out_l), .out_right(out_r), .out_valid(ov), .gain_level(gl),
    .conv_muted(cm));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      num_errors++;
      test_done();
    end
  end

  // ---------------------------------------------------------------
  // bus and check tasks
  // ---------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done

  task automatic tk();
    @(posedge clk);
    #1;
  endtask : tk

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_s <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    rv = rdata;
  endtask : rd

  task automatic drv(input logic [7:0] u, input logic [1:0] s,
                     input logic sl);
    @(posedge clk);
    unlock <= u;
    cond_sel <= s;
    slow <= sl;
    #1;
  endtask : drv

  // unit gain steps, each after a strobe, up to target t
  task automatic ramp(input int c, input amr_gain_t t, input int mx,
                      input string n);
    amr_gain_t g;
    logic s;
    g = gl[c];
    s = stb[c];
    repeat (mx) begin
      if (gl[c] === t) break;
      tk();
      if (gl[c] !== g) begin
        `CHK(n, (t > g) ? g + 12'h001 : g - 12'h001, gl[c])
        `CHK(n, 1'b1, s)
      end
      g = gl[c];
      s = stb[c];
    end
    `CHK(n, t, gl[c])
    tk();
    `CHK(n, t == 12'h000, cm[c])
  endtask : ramp

  task automatic out_chk(input int c, input string n);
    amr_sample_t x;
    amr_sample_t y;
    amr_gain_t g;
    logic signed [36:0] p;
    logic signed [36:0] q;
    tk();
    while (stb[c] !== 1'b1) tk();
    x = in_l[c];
    y = in_r[c];
    g = gl[c];
    tk();
    p = x * $signed({1'b0, g});
    q = y * $signed({1'b0, g});
    `CHK(n, 1'b1, ov[c])
    `CHK(n, p[34:11], out_l[c])
    `CHK(n, q[34:11], out_r[c])
  endtask : out_chk

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    rd(MR);
    `CHK("mute rst", 16'h0000, rv)
    `CHK("gain rst", {8{12'h800}}, gl)
    `CHK("muted rst", 8'h00, cm)
    wr(MR, 16'hFFFF);
    wr(16'hF583, 16'h0000);
    rd(16'hF583);
    `CHK("unmapped", 16'h0000, rv)
    rd(MR);
    `CHK("mute mask", 16'h07FF, rv)
    `CHK("dis gain", {8{12'h800}}, gl)
    wr(MR, 16'h0000);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_manual();
    wr(MR, 16'h0011);
    ramp(0, 12'h000, 9000, "down0");
    `CHK("down4", 12'h000, gl[4])
    rd(16'hF582);
    `CHK("status", 16'h0011, rv)
    out_chk(0, "out mute");
    wr(MR, 16'h0000);
    ramp(0, 12'h800, 9000, "up0");
    out_chk(0, "out unity");
    drv(8'h00, 2'h0, 1'b1);
    wr(MR, 16'h0001);
    ramp(0, 12'h780, 600, "rev down");
    out_chk(0, "out mid");
    wr(MR, 16'h0000);
    ramp(0, 12'h800, 9000, "rev up");
    drv(8'h00, 2'h0, 1'b0);
    $display("t_manual done");
  endtask : t_manual

  task automatic t_freeze();
    amr_gain_t g;
    wr(MR, 16'h0001);
    repeat (5) tk();
    @(posedge clk);
    ce <= 1'b0;
    #1;
    g = gl[0];
    repeat (20) tk();
    `CHK("frozen ramp", 1'b1, g < 12'h800)
    `CHK("freeze", g, gl[0])
    @(posedge clk);
    ce <= 1'b1;
    #1;
    wr(MR, 16'h0000);
    ramp(0, 12'h800, 9000, "thaw up");
    $display("t_freeze done");
  endtask : t_freeze

  task automatic t_group();
    wr(MR, 16'h0111);
    repeat (20) tk();
    `CHK("grp0 gain", 12'h800, gl[0])
    ramp(4, 12'h000, 9000, "grp1 down");
    wr(MR, 16'h0211);
    repeat (3) tk();
    `CHK("grp1 gain", 12'h800, gl[4])
    `CHK("grp1 muted", 1'b0, cm[4])
    ramp(0, 12'h000, 9000, "grp0 down");
    wr(MR, 16'h0000);
    ramp(0, 12'h800, 9000, "grp0 up");
    $display("t_group done");
  endtask : t_group

  task automatic t_lock();
    drv(8'h02, 2'h0, 1'b0);
    repeat (50) tk();
    `CHK("no auto", 12'h800, gl[1])
    rd(`AMR_LOCK_OFS);
    `CHK("lock flags", 16'h00FD, rv)
    wr(MR, 16'h0500);
    repeat (50) tk();
    `CHK("auto grp off", 12'h800, gl[1])
    wr(MR, 16'h0400);
    ramp(1, 12'h000, 9000, "auto down");
    drv(8'h00, 2'h0, 1'b0);
    ramp(1, 12'h800, 9000, "relock up");
    wr(MR, 16'h0402);
    ramp(1, 12'h000, 9000, "man down");
    drv(8'h02, 2'h0, 1'b0);
    repeat (10) tk();
    drv(8'h00, 2'h0, 1'b0);
    repeat (50) tk();
    `CHK("man holds", 1'b1, cm[1])
    wr(MR, 16'h0400);
    ramp(1, 12'h800, 9000, "man up");
    for (int s = 1; s < 3; s++) begin
      drv(8'h0D, s[1:0], 1'b0);
      ramp(2, 12'h000, 9000, "cond down");
      drv(8'h00, s[1:0], 1'b0);
      ramp(2, 12'h800, 9000, "cond up");
    end
    $display("t_lock done");
  endtask : t_lock

  initial begin
    rst_n = 1'b0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    addr = 16'h0000;
    wdata = 16'h0000;
    unlock = 8'h00;
    cond_sel = 2'h0;
    slow = 1'b0;
    ce = 1'b1;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    t_regs();
    t_freeze();
    t_manual();
    t_group();
    t_lock();
    test_done();
  end
endmodule : converter_mute_control_ramp_control_tb_top
